// file: isf_dev_end.sv
/*
 Status-flag logic of a master/slave two-wire bus controller: arbitration lost,
 range match, slave direction and pending interrupt, with its own registers on
 a classic Wishbone slave and the acknowledge drive toward the link.
 Assumes one clock shared with the far agent and 32-bit Wishbone with byte lane 0 used.
*/
`include "isf_regs.svh"
`default_nettype none

// Functional notes
// - Arbitration loss sets the lost flag.
// - Writing one clears lost flag, nothing else.
// - Window enabled: nonzero call equals upper address.
// - Window enabled: call within primary..upper range.
// - Software keeps interrupt enable set for range matching.
// - Any first-control write clears range match.
// - Direction flag holds received read/write bit.
// - Any interrupt event sets interrupt flag.
// - Writing one clears interrupt flag, nothing else.
// - Fast ack off: flag after acknowledge bit.
// - Fast ack on: flag after eight bits.
// - Receive: drive ack or nack from control.
// - Address match, arbitration, SMBus timeouts except SCL/SDA high interrupt.
module isf_dev_end (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// Interrupt request
	output logic irqReq,
	// Link
	isf_link_if.dev link
);

	function automatic logic isf_in_window(
		input logic [6:0] a,
		input logic [6:0] lo,
		input logic [6:0] hi
	);
		isf_in_window = (a >= lo) && (a <= hi);
	endfunction : isf_in_window

	// Register select, shared by write decode and read mux
	function automatic logic isf_adr_hit(
		input logic [7:0] adr,
		input logic [7:0] ofs
	);
		isf_adr_hit = (adr == ofs);
	endfunction : isf_adr_hit

	// Sticky flag: a set event wins over a clear in the same cycle
	function automatic logic isf_sticky(
		input logic setEv,
		input logic held,
		input logic clrEv
	);
		isf_sticky = setEv | (held & ~clrEv);
	endfunction : isf_sticky

	isf_pkg::isf_dev_state_t st;
	isf_pkg::isf_dev_state_t nx;

	logic busAcc;
	logic busWr;
	logic wrStatus;
	logic wrCtrl1;
	logic wrCtrl2;
	logic wrCfg;
	logic wrAddr1;
	logic wrUpper;
	logic primaryHit;
	logic rangeHit;
	logic callHit;
	logic byteSet;
	logic toutSet;
	logic intSet;
	logic [7:0] rdByte;

	// Bus access decode
	assign busAcc = wbCyc & wbStb & ~st.wbAck;
	assign busWr = busAcc & wbWe & wbSel[0];
	assign wrStatus = busWr & isf_adr_hit(wbAdr, `ISF_OFS_STATUS);
	assign wrCtrl1 = busWr & isf_adr_hit(wbAdr, `ISF_OFS_CTRL1);
	assign wrCtrl2 = busWr & isf_adr_hit(wbAdr, `ISF_OFS_CTRL2);
	assign wrCfg = busWr & isf_adr_hit(wbAdr, `ISF_OFS_CFG);
	assign wrAddr1 = busWr & isf_adr_hit(wbAdr, `ISF_OFS_ADDR1);
	assign wrUpper = busWr & isf_adr_hit(wbAdr, `ISF_OFS_UPPER);

	// Calling address match
	assign primaryHit = (link.callAddr != 7'h00)
		&& isf_in_window(link.callAddr, st.primAddr, st.primAddr);
	assign rangeHit = st.windowEn && st.irqEnable
		&& (link.callAddr != 7'h00)
		&& ((link.callAddr == st.upperAddr)
		|| isf_in_window(link.callAddr, st.primAddr, st.upperAddr));
	assign callHit = link.callStb & (primaryHit | rangeHit);

	// Interrupt causes
	assign byteSet = st.fastAck ? link.bitsStb : link.ackStb;
	assign toutSet = link.toutStb & st.smbusMode
		& (link.toutKind != `ISF_TOUT_SCL_HIGH)
		& (link.toutKind != `ISF_TOUT_SDA_HIGH);
	assign intSet = byteSet | callHit | link.arbStb | toutSet;

	always_comb begin
		nx = st;
		rdByte = `ISF_RST_BYTE;
		// Read mux
		if (isf_adr_hit(wbAdr, `ISF_OFS_STATUS)) begin
			rdByte[`ISF_ST_ARB_LOST] = st.arbLost;
			rdByte[`ISF_ST_RANGE] = st.rangeMatch;
			rdByte[`ISF_ST_DIR] = st.slaveDir;
			rdByte[`ISF_ST_INT] = st.intFlag;
		end else if (isf_adr_hit(wbAdr, `ISF_OFS_CTRL1)) begin
			rdByte[`ISF_C1_IRQ_EN] = st.irqEnable;
			rdByte[`ISF_C1_TX_MODE] = st.txMode;
			rdByte[`ISF_C1_TX_ACK] = st.txAck;
		end else if (isf_adr_hit(wbAdr, `ISF_OFS_CTRL2)) begin
			rdByte[`ISF_C2_WIN_EN] = st.windowEn;
		end else if (isf_adr_hit(wbAdr, `ISF_OFS_CFG)) begin
			rdByte[`ISF_CFG_FAST_ACK] = st.fastAck;
			rdByte[`ISF_CFG_SMBUS] = st.smbusMode;
		end else if (isf_adr_hit(wbAdr, `ISF_OFS_ADDR1)) begin
			rdByte[`ISF_ADDR_MSB:`ISF_ADDR_LSB] = st.primAddr;
		end else if (isf_adr_hit(wbAdr, `ISF_OFS_UPPER)) begin
			rdByte[`ISF_ADDR_MSB:`ISF_ADDR_LSB] = st.upperAddr;
		end
		// Bus answer: one-cycle ack, unmapped reads zero
		nx.wbAck = busAcc;
		if (busAcc && !wbWe) begin
			nx.rdData = {24'h000000, rdByte};
		end
		// Register writes
		if (wrCtrl1) begin
			nx.irqEnable = wbDatW[`ISF_C1_IRQ_EN];
			nx.txMode = wbDatW[`ISF_C1_TX_MODE];
			nx.txAck = wbDatW[`ISF_C1_TX_ACK];
		end
		if (wrCtrl2) begin
			nx.windowEn = wbDatW[`ISF_C2_WIN_EN];
		end
		if (wrCfg) begin
			nx.fastAck = wbDatW[`ISF_CFG_FAST_ACK];
			nx.smbusMode = wbDatW[`ISF_CFG_SMBUS];
		end
		if (wrAddr1) begin
			nx.primAddr = wbDatW[`ISF_ADDR_MSB:`ISF_ADDR_LSB];
		end
		if (wrUpper) begin
			nx.upperAddr = wbDatW[`ISF_ADDR_MSB:`ISF_ADDR_LSB];
		end
		// Sticky flags: set wins over clear
		nx.arbLost = isf_sticky(link.arbStb, st.arbLost,
			wrStatus & wbDatW[`ISF_ST_ARB_LOST]);
		nx.rangeMatch = isf_sticky(link.callStb & rangeHit, st.rangeMatch,
			wrCtrl1);
		nx.intFlag = isf_sticky(intSet, st.intFlag,
			wrStatus & wbDatW[`ISF_ST_INT]);
		// Direction follows the call that matched
		if (callHit) begin
			nx.slaveDir = link.callRw;
		end
		// Acknowledge drive for a received byte
		if (wrCtrl1 && st.ackPending) begin
			nx.ackWritten = 1'b1;
		end
		if (link.bitsStb && !st.txMode) begin
			nx.ackPending = 1'b1;
			nx.ackWritten = 1'b0;
		end
		if (link.ackStb) begin
			nx.ackPending = 1'b0;
			nx.ackWritten = 1'b0;
		end
		nx.ackReady = nx.ackPending & (~nx.fastAck | nx.ackWritten);
		nx.ackOut = nx.txAck;
		// Enable is low while the acknowledge is driven
		nx.ackOeN = ~nx.ackReady;
		// Request output follows flag and enable
		nx.irq = nx.intFlag & nx.irqEnable;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.ackOeN <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	assign wbAck = st.wbAck;
	assign wbDatR = st.rdData;
	assign irqReq = st.irq;
	assign link.ackReady = st.ackReady;
	assign link.ackOut = st.ackOut;
	assign link.ackOeN = st.ackOeN;

endmodule : isf_dev_end

`default_nettype wire

// file: isf_regs.svh
/*
 Offsets, field positions, reset values and codes of the status-flag block.
 Assumes inclusion by bare name from every file that needs these values.
*/
`ifndef ISF_REGS_SVH
`define ISF_REGS_SVH

// Register byte offsets on the Wishbone bus
`define ISF_OFS_STATUS 8'h00
`define ISF_OFS_CTRL1 8'h04
`define ISF_OFS_CTRL2 8'h08
`define ISF_OFS_CFG 8'h0C
`define ISF_OFS_ADDR1 8'h10
`define ISF_OFS_UPPER 8'h14

// Status register fields
`define ISF_ST_ARB_LOST 4
`define ISF_ST_RANGE 3
`define ISF_ST_DIR 2
`define ISF_ST_INT 1

// First control register fields
`define ISF_C1_IRQ_EN 6
`define ISF_C1_TX_MODE 4
`define ISF_C1_TX_ACK 3

// Second control register field
`define ISF_C2_WIN_EN 3

// Configuration register fields
`define ISF_CFG_FAST_ACK 7
`define ISF_CFG_SMBUS 6

// Address fields sit in bits 7:1
`define ISF_ADDR_LSB 1
`define ISF_ADDR_MSB 7

// Reset value of every register byte
`define ISF_RST_BYTE 8'h00

// Timeout kinds on the link
`define ISF_TOUT_LOW 2'h0
`define ISF_TOUT_SCL_HIGH 2'h1
`define ISF_TOUT_SDA_HIGH 2'h2

`endif

// file: isf_pkg.sv
/*
 Types of the status-flag block: state records of both ends and command kinds.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package isf_pkg;

	typedef enum logic [1:0] {
		ISF_CMD_CALL,
		ISF_CMD_BYTE,
		ISF_CMD_ARB,
		ISF_CMD_TOUT
	} isf_cmd_t;

	typedef enum logic [1:0] {
		ISF_FAR_IDLE,
		ISF_FAR_GAP,
		ISF_FAR_WAIT
	} isf_far_state_t;

	typedef struct packed {
		logic wbAck;
		logic [31:0] rdData;
		logic irqEnable;
		logic txMode;
		logic txAck;
		logic windowEn;
		logic fastAck;
		logic smbusMode;
		logic [6:0] primAddr;
		logic [6:0] upperAddr;
		logic arbLost;
		logic rangeMatch;
		logic slaveDir;
		logic intFlag;
		logic ackPending;
		logic ackWritten;
		logic ackReady;
		logic ackOut;
		logic ackOeN;
		logic irq;
	} isf_dev_state_t;

	typedef struct packed {
		isf_far_state_t state;
		logic ready;
		logic done;
		logic doneAck;
		logic callStb;
		logic [6:0] callAddr;
		logic callRw;
		logic bitsStb;
		logic ackStb;
		logic arbStb;
		logic toutStb;
		logic [1:0] toutKind;
	} isf_far_state_t_rec_t;

endpackage : isf_pkg

`default_nettype wire

// file: isf_link_if.sv
/*
 Link between the flag block and the far bus agent: byte-phase events one way,
 the acknowledge drive the other way.
 Assumes both ends run on one clock; the bench joins them.
*/
`default_nettype none

interface isf_link_if;
	// Far agent to device
	logic callStb;
	logic [6:0] callAddr;
	logic callRw;
	logic bitsStb;
	logic ackStb;
	logic arbStb;
	logic toutStb;
	logic [1:0] toutKind;
	// Device to far agent
	logic ackReady;
	logic ackOut;
	logic ackOeN;

	modport dev (
		input callStb, callAddr, callRw, bitsStb, ackStb, arbStb, toutStb, toutKind,
		output ackReady, ackOut, ackOeN
	);

	modport far (
		output callStb, callAddr, callRw, bitsStb, ackStb, arbStb, toutStb, toutKind,
		input ackReady, ackOut, ackOeN
	);
endinterface : isf_link_if

`default_nettype wire

// file: isf_far_end.sv
/*
 Far bus agent: turns user commands into byte-phase events on the link and
 reports the acknowledge seen from the device.
 Assumes one clock shared with the device end and a user that waits for cmdReady.
*/
`include "isf_regs.svh"
`default_nettype none

module isf_far_end (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// User commands
	input wire logic cmdValid,
	input wire isf_pkg::isf_cmd_t cmdKind,
	input wire logic [6:0] cmdAddr,
	input wire logic cmdRw,
	input wire logic cmdFarWrites,
	input wire logic cmdOwnAck,
	input wire logic [1:0] cmdTimeout,
	output logic cmdReady,
	output logic doneValid,
	output logic doneAck,
	// Link
	isf_link_if.far link
);

	isf_pkg::isf_far_state_t_rec_t st;
	isf_pkg::isf_far_state_t_rec_t nx;

	always_comb begin
		nx = st;
		nx.done = 1'b0;
		nx.callStb = 1'b0;
		nx.bitsStb = 1'b0;
		nx.ackStb = 1'b0;
		nx.arbStb = 1'b0;
		nx.toutStb = 1'b0;
		case (st.state)
			isf_pkg::ISF_FAR_IDLE: begin
				if (cmdValid && st.ready) begin
					case (cmdKind)
						isf_pkg::ISF_CMD_CALL: begin
							nx.callStb = 1'b1;
							nx.callAddr = cmdAddr;
							nx.callRw = cmdRw;
							nx.done = 1'b1;
							nx.doneAck = 1'b0;
						end
						isf_pkg::ISF_CMD_BYTE: begin
							nx.bitsStb = 1'b1;
							nx.doneAck = cmdOwnAck;
							// Device receives: wait until it drives its acknowledge
							if (cmdFarWrites) begin
								nx.state = isf_pkg::ISF_FAR_WAIT;
							end else begin
								nx.state = isf_pkg::ISF_FAR_GAP;
							end
						end
						isf_pkg::ISF_CMD_ARB: begin
							nx.arbStb = 1'b1;
							nx.done = 1'b1;
							nx.doneAck = 1'b0;
						end
						default: begin
							nx.toutStb = 1'b1;
							nx.toutKind = cmdTimeout;
							nx.done = 1'b1;
							nx.doneAck = 1'b0;
						end
					endcase
				end
			end
			isf_pkg::ISF_FAR_GAP: begin
				nx.ackStb = 1'b1;
				// Shared line: a low driven by the device wins
				nx.doneAck = st.doneAck & (link.ackOeN | link.ackOut);
				nx.done = 1'b1;
				nx.state = isf_pkg::ISF_FAR_IDLE;
			end
			isf_pkg::ISF_FAR_WAIT: begin
				if (link.ackReady) begin
					nx.ackStb = 1'b1;
					nx.done = 1'b1;
					// Undriven line reads as not-acknowledge
					nx.doneAck = link.ackOeN ? 1'b1 : link.ackOut;
					nx.state = isf_pkg::ISF_FAR_IDLE;
				end
			end
			default: begin
				nx.state = isf_pkg::ISF_FAR_IDLE;
			end
		endcase
		nx.ready = (nx.state == isf_pkg::ISF_FAR_IDLE) && !(cmdValid && st.ready);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign cmdReady = st.ready;
	assign doneValid = st.done;
	assign doneAck = st.doneAck;
	assign link.callStb = st.callStb;
	assign link.callAddr = st.callAddr;
	assign link.callRw = st.callRw;
	assign link.bitsStb = st.bitsStb;
	assign link.ackStb = st.ackStb;
	assign link.arbStb = st.arbStb;
	assign link.toutStb = st.toutStb;
	assign link.toutKind = st.toutKind;

endmodule : isf_far_end

`default_nettype wire

// file: isf_tb_assertions.sv
/*
 Checker of the link between the device end and the far agent.
 Assumes the bench feeds it the link signals on one clock with async reset.
*/
`default_nettype none

module isf_tb_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Far to device
	input wire logic callStb,
	input wire logic bitsStb,
	input wire logic ackStb,
	input wire logic arbStb,
	input wire logic toutStb,
	// Device to far
	input wire logic ackReady,
	input wire logic ackOut,
	input wire logic ackOeN
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	AST_OE_FOLLOWS: assert property (ackOeN == !ackReady)
		else $error("ack enable not inverse of ready");
	AST_ACK_AFTER_READY: assert property ($rose(ackReady) |=> ackStb)
		else $error("byte not closed after ack drive");
	AST_READY_DROPS: assert property (ackStb |=> !ackReady)
		else $error("ack drive kept after byte end");
	AST_OUT_STEADY: assert property (ackReady && $past(ackReady) |-> $stable(ackOut))
		else $error("ack value moved while driven");
	AST_BITS_PULSE: assert property (bitsStb |=> !bitsStb)
		else $error("data bits strobe too long");
	AST_ONE_EVENT: assert property ($onehot0({callStb, bitsStb, ackStb, arbStb, toutStb}))
		else $error("two link events at once");
	AST_ACK_CAUSE: assert property (ackStb |-> $past(bitsStb) || $past(ackReady))
		else $error("ack phase without byte");
	AST_NO_DRIVE_IN_BITS: assert property (bitsStb |-> !ackReady)
		else $error("ack driven during data bits");
endmodule : isf_tb_assertions

`default_nettype wire

// file: tb.sv
/*
 Bench: both ends joined by the link, Wishbone and command tasks.
 Assumes the design files and the checker compile before it.
*/
`include "isf_regs.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, cv = 1'h0, cRw = 1'h0, cFw = 1'h0, cOa = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] datW = 32'h0, datR;
	logic [3:0] sel = 4'h0;
	logic [6:0] cAdr = 7'h0;
	logic [1:0] cTo = 2'h0;
	isf_pkg::isf_cmd_t cKind = isf_pkg::ISF_CMD_CALL;
	logic ack, irq, cRdy, dv, dAck;
	logic [7:0] q;
	int n_errors = 0, comparisons = 0;
	isf_link_if link ();
	always #25 clk = ~clk;

	isf_dev_end isf_dev_end_i (.core_clk(clk), .rst_n(rst_n), .wbCyc(cyc), .wbStb(stb),
		.wbWe(we), .wbAdr(adr), .wbSel(sel), .wbDatW(datW), .wbDatR(datR),
		.wbAck(ack), .irqReq(irq), .link(link));
	isf_far_end isf_far_end_i (.core_clk(clk), .rst_n(rst_n), .cmdValid(cv),
		.cmdKind(cKind), .cmdAddr(cAdr), .cmdRw(cRw), .cmdFarWrites(cFw),
		.cmdOwnAck(cOa), .cmdTimeout(cTo), .cmdReady(cRdy), .doneValid(dv),
		.doneAck(dAck), .link(link));
	isf_tb_assertions isf_tb_assertions_i (.core_clk(clk), .rst_n(rst_n),
		.callStb(link.callStb), .bitsStb(link.bitsStb), .ackStb(link.ackStb),
		.arbStb(link.arbStb), .toutStb(link.toutStb), .ackReady(link.ackReady),
		.ackOut(link.ackOut), .ackOeN(link.ackOeN));

	task close_out;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		datW <= {24'h0, d};
		sel <= 4'hF;
		do begin
			@(posedge clk);
		end while (ack !== 1'h1);
		q = datR[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'h1, a, d);
	endtask : wr

	task st(input logic [7:0] exp);
		wb(1'h0, `ISF_OFS_STATUS, 8'h00);
		chk("status", q, exp);
	endtask : st

	task go(input isf_pkg::isf_cmd_t k, input logic [6:0] a, input logic rw,
		input logic fw, input logic [1:0] to);
		@(posedge clk);
		cKind <= k;
		cAdr <= a;
		cRw <= rw;
		cFw <= fw;
		cTo <= to;
		cv <= 1'h1;
		do begin
			@(posedge clk);
		end while (cRdy !== 1'h1);
		cv <= 1'h0;
	endtask : go

	task done;
		do begin
			@(posedge clk);
		end while (dv !== 1'h1);
		q = {7'h0, dAck};
		@(posedge clk);
	endtask : done

	task t_reset;
		for (int k = 0; k < 7; k++) begin
			wb(1'h0, 8'(k * 4), 8'h00);
			chk("reset value", q, 8'h00);
		end
		$display("test reset done");
	endtask : t_reset

	task t_arb;
		wr(`ISF_OFS_CTRL1, 8'h40);
		go(isf_pkg::ISF_CMD_ARB, 7'h0, 1'h0, 1'h0, 2'h0);
		done;
		st(8'h12);
		chk("irq", {7'h0, irq}, 8'h01);
		wr(`ISF_OFS_STATUS, 8'h02);
		st(8'h10);
		chk("irq", {7'h0, irq}, 8'h00);
		wr(`ISF_OFS_STATUS, 8'h10);
		st(8'h00);
		$display("test arbitration done");
	endtask : t_arb

	task t_range;
		wr(`ISF_OFS_CTRL2, 8'h08);
		wr(`ISF_OFS_ADDR1, 8'h20);
		wr(`ISF_OFS_UPPER, 8'h40);
		go(isf_pkg::ISF_CMD_CALL, 7'h18, 1'h1, 1'h0, 2'h0);
		done;
		st(8'h0E);
		wr(`ISF_OFS_CTRL1, 8'h40);
		st(8'h06);
		wr(`ISF_OFS_STATUS, 8'h02);
		go(isf_pkg::ISF_CMD_CALL, 7'h20, 1'h0, 1'h0, 2'h0);
		done;
		st(8'h0A);
		wr(`ISF_OFS_CTRL1, 8'h40);
		wr(`ISF_OFS_STATUS, 8'h02);
		go(isf_pkg::ISF_CMD_CALL, 7'h30, 1'h1, 1'h0, 2'h0);
		done;
		st(8'h00);
		wr(`ISF_OFS_CTRL2, 8'h00);
		go(isf_pkg::ISF_CMD_CALL, 7'h10, 1'h1, 1'h0, 2'h0);
		done;
		st(8'h06);
		wr(`ISF_OFS_STATUS, 8'h02);
		go(isf_pkg::ISF_CMD_CALL, 7'h10, 1'h0, 1'h0, 2'h0);
		done;
		st(8'h02);
		wr(`ISF_OFS_STATUS, 8'h02);
		$display("test range done");
	endtask : t_range

	task t_byte;
		wr(`ISF_OFS_CFG, 8'h00);
		wr(`ISF_OFS_CTRL1, 8'h48);
		go(isf_pkg::ISF_CMD_BYTE, 7'h0, 1'h0, 1'h1, 2'h0);
		done;
		chk("nack", q, 8'h01);
		st(8'h02);
		wr(`ISF_OFS_STATUS, 8'h02);
		wr(`ISF_OFS_CFG, 8'h80);
		wr(`ISF_OFS_CTRL1, 8'h40);
		go(isf_pkg::ISF_CMD_BYTE, 7'h0, 1'h0, 1'h1, 2'h0);
		repeat (3) @(posedge clk);
		st(8'h02);
		wr(`ISF_OFS_CTRL1, 8'h40);
		done;
		chk("ack", q, 8'h00);
		wr(`ISF_OFS_STATUS, 8'h02);
		wr(`ISF_OFS_CFG, 8'h00);
		wr(`ISF_OFS_CTRL1, 8'h50);
		cOa <= 1'h1;
		go(isf_pkg::ISF_CMD_BYTE, 7'h0, 1'h0, 1'h0, 2'h0);
		done;
		chk("far ack", q, 8'h01);
		st(8'h02);
		wr(`ISF_OFS_STATUS, 8'h02);
		$display("test byte done");
	endtask : t_byte

	task t_tout;
		wr(`ISF_OFS_CFG, 8'h40);
		for (int k = 0; k < 4; k++) begin
			go(isf_pkg::ISF_CMD_TOUT, 7'h0, 1'h0, 1'h0, 2'(k));
			done;
			st((k == 1 || k == 2) ? 8'h00 : 8'h02);
			wr(`ISF_OFS_STATUS, 8'h02);
		end
		$display("test timeout done");
	endtask : t_tout

	initial begin
		#200000;
		n_errors++;
		close_out;
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		t_reset;
		t_arb;
		t_range;
		t_byte;
		t_tout;
		close_out;
	end
endmodule : tb

`default_nettype wire
